//--- core/bcseq_pkg.sv
/*
 bcseq_pkg: constants, field layout, enumerations and helper functions for the
 bus interface unit command-list sequencer.
 Assumes 16-bit memory words and 5-bit device addresses.
*/
package bcseq_pkg;
	localparam int W = 16;
	localparam int AW = 16;
	// first instruction word fields
	localparam int OP_HI = 15;
	localparam int OP_LO = 14;
	localparam int RETRY_BIT = 13;
	localparam int INTR_BIT = 11;
	localparam int RDA_HI = 10;
	localparam int RDA_LO = 6;
	localparam int RSA_HI = 4;
	localparam int RSA_LO = 0;
	// second instruction word fields
	localparam int CNT_HI = 15;
	localparam int CNT_LO = 11;
	localparam int BSEL_BIT = 10;
	localparam int TDA_HI = 9;
	localparam int TDA_LO = 5;
	localparam int TSA_HI = 4;
	localparam int TSA_LO = 0;
	localparam logic [1:0] OP_HALT = 2'h0;
	localparam logic [1:0] OP_NOP = 2'h1;
	localparam logic [1:0] OP_BUS = 2'h3;
	localparam logic DIR_RX = 1'h0;
	localparam logic DIR_TX = 1'h1;
	localparam logic [1:0] RETRY_MAX = 2'h3;
	localparam logic [AW-1:0] ONE = 16'h0001;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [4:0] ZERO5 = 5'h00;
	localparam logic [4:0] MC_MFI = 5'h12;
	localparam logic [4:0] MC_BUSY_OVR = 5'h14;
	localparam logic [4:0] MC_SYS_INT = 5'h15;
	localparam logic [4:0] MC_UNDEF_LO = 5'h16;

	typedef enum logic [3:0] {
		BCS_IDLE = 4'h0,
		BCS_FETCH1 = 4'h1,
		BCS_FETCH2 = 4'h3,
		BCS_DECODE = 4'h2,
		BCS_CMD = 4'h6,
		BCS_DATA = 4'h7,
		BCS_RESULT = 4'h5,
		BCS_DONE = 4'h4,
		BCS_PAUSE = 4'hC,
		BCS_HALTED = 4'hD
	} bcseq_state_e;

	// remote-mode validity of a received mode code
	function automatic logic bcseq_remote_valid(input logic [4:0] mc);
		case (mc)
			5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h11, 5'h12, 5'h14,
			5'h15: bcseq_remote_valid = 1'b1;
			default: bcseq_remote_valid = 1'b0;
		endcase
	endfunction : bcseq_remote_valid

	// bus command word: address, direction, subaddress, count
	function automatic logic [W-1:0] bcseq_cmd(input logic [4:0] da, input logic dir,
			input logic [4:0] sa, input logic [4:0] cnt);
		bcseq_cmd = {da, dir, sa, cnt};
	endfunction : bcseq_cmd
endpackage : bcseq_pkg

//--- core/bcseq_buf2.sv
/*
 bcseq_buf2: two-entry buffer with valid/ready on both sides.
 Assumes one clock; outputs decoded from register state.
*/
`timescale 1ns/1ps
module bcseq_buf2
	import bcseq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [W-1:0] mem_reg [2];
	logic wp_reg;
	logic rp_reg;
	logic [1:0] cnt_reg;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = mem_reg[rp_reg];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push)
				wp_reg <= ~wp_reg;
			if (pop)
				rp_reg <= ~rp_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wp_reg] <= in_data;
	end
endmodule : bcseq_buf2

//--- core/bcseq_top.sv
/*
 bcseq_top: command-list sequencer of a bus interface unit.
 Assumes a memory port answering one word per accepted request, a bus engine that
 takes command/data words through a two-entry buffer and reports a transfer result,
 and host control bits presented as plain same-clock ports.
*/
// Overview of operation
// - transfer address starts at data area pointer plus one, skipping tag word
// - transfer address increments after every data word stored to memory
// - remaining count loads from count field, decrements per data word stored to memory
// - remote mode sends nothing unless commanded by the master
// - instructions are two words with fixed field layout
// - op code 00 halts, sets halt flag, raises level 1 interrupt
// - nop with interrupt flag pauses until host sets continue
// - op code 11 treats remaining fields as bus transfer
// - failed transfer with retry set repeats at most three more times
// - interrupt flag and success set program interrupt flag, level 1 interrupt
// - foreign receive address produces receive command sent on bus
// - own receive address with nonzero subaddress loads transfer address
// - count field gives word count or mode code number
// - bus select clear uses first bus, set uses second
// - foreign transmit address forms transmit command; own sends no memory data and no mode payload
// - both subaddresses zero means mode command aimed at transmit address
// - equal receive and transmit addresses flag invalid instruction, interrupt
// - mode payload register is never sent on the bus; returned mode data is stored in it
// - undefined mode codes 22 to 31 expect only a status reply
// - remote mode accepts only listed mode codes, others invalid
// - remote mode code 18 stores next word in master function register, interrupts
// - code 20 clears busy-continue; code 21 raises system interrupt
// - instruction pointer holds next fetch address and advances per fetched word
// - invalid mode code sets invalid-command bit and sends status with error
`timescale 1ns/1ps
module bcseq_top
	import bcseq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic master_mode,
	input wire logic [4:0] own_address,
	input wire logic start,
	input wire logic [AW-1:0] start_address,
	input wire logic continue_set,
	input wire logic mode_payload_load,
	input wire logic [W-1:0] mode_payload_in,
	input wire logic busy_continue_set,
	input wire logic [AW-1:0] data_area_pointer,
	output logic mem_req,
	output logic mem_we,
	output logic [AW-1:0] mem_addr,
	output logic [W-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [W-1:0] mem_rdata,
	output logic [W-1:0] bus_word,
	output logic bus_word_valid,
	input wire logic bus_word_ready,
	output logic bus_word_is_cmd,
	output logic bus_select,
	output logic expect_status_only,
	input wire logic xfer_done,
	input wire logic xfer_ok,
	input wire logic rx_word_valid,
	input wire logic [W-1:0] rx_word,
	input wire logic remote_cmd_valid,
	input wire logic [4:0] remote_mode_code,
	input wire logic remote_data_valid,
	input wire logic [W-1:0] remote_data,
	output logic halt_flag,
	output logic pci_flag,
	output logic invalid_instruction_flag,
	output logic level1_irq,
	output logic [AW-1:0] instruction_pointer_register,
	output logic [AW-1:0] transfer_address_register,
	output logic [4:0] remaining_count_register,
	output logic [W-1:0] mode_payload_register,
	output logic [W-1:0] master_function_register,
	output logic master_function_irq,
	output logic system_irq,
	output logic busy_continue,
	output logic invalid_command_bit,
	output logic status_error_reply,
	output logic paused
);
	bcseq_state_e state_reg;
	logic [W-1:0] iw1_reg;
	logic [W-1:0] iw2_reg;
	logic [1:0] retry_reg;
	logic [1:0] phase_reg;
	logic mfr_wait_reg;
	logic [W-1:0] q_data;
	logic q_valid;
	logic q_ready;
	logic [W-1:0] bw_data;
	logic bw_valid;
	logic [4:0] rda, rsa, tda, tsa, cnt;
	logic is_mode, rx_own, tx_own, mem_go, rd_go, pushing, data_out;

	assign rda = iw1_reg[RDA_HI:RDA_LO];
	assign rsa = iw1_reg[RSA_HI:RSA_LO];
	assign cnt = iw2_reg[CNT_HI:CNT_LO];
	assign tda = iw2_reg[TDA_HI:TDA_LO];
	assign tsa = iw2_reg[TSA_HI:TSA_LO];
	assign is_mode = (rsa == ZERO5) && (tsa == ZERO5);
	assign rx_own = (rda == own_address);
	assign tx_own = (tda == own_address);
	assign mem_go = mem_req && mem_ack;
	assign rd_go = mem_go && !mem_we;
	assign data_out = tx_own && !is_mode;
	assign pushing = bw_valid && q_ready;
	assign bus_word_valid = q_valid;
	assign bus_word = q_data;

	bcseq_buf2 u_buf (
		.clk(clk),
		.rst(rst),
		.in_data(bw_data),
		.in_valid(bw_valid),
		.in_ready(q_ready),
		.out_data(q_data),
		.out_valid(q_valid),
		.out_ready(bus_word_ready)
	);

	// sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= BCS_IDLE;
			iw1_reg <= 16'h0000;
			iw2_reg <= 16'h0000;
			retry_reg <= 2'h0;
			phase_reg <= 2'h0;
			instruction_pointer_register <= 16'h0000;
		end else begin
			case (state_reg)
				BCS_IDLE, BCS_HALTED: begin
					if (start && master_mode) begin
						instruction_pointer_register <= start_address;
						state_reg <= BCS_FETCH1;
					end
				end
				BCS_FETCH1: begin
					if (rd_go) begin
						iw1_reg <= mem_rdata;
						instruction_pointer_register <= instruction_pointer_register + ONE;
						state_reg <= BCS_FETCH2;
					end
				end
				BCS_FETCH2: begin
					if (rd_go) begin
						iw2_reg <= mem_rdata;
						instruction_pointer_register <= instruction_pointer_register + ONE;
						retry_reg <= 2'h0;
						state_reg <= BCS_DECODE;
					end
				end
				BCS_DECODE: begin
					phase_reg <= 2'h0;
					if (iw1_reg[OP_HI:OP_LO] == OP_HALT)
						state_reg <= BCS_HALTED;
					else if (iw1_reg[OP_HI:OP_LO] == OP_NOP)
						state_reg <= iw1_reg[INTR_BIT] ? BCS_PAUSE : BCS_FETCH1;
					else if (iw1_reg[OP_HI:OP_LO] != OP_BUS)
						state_reg <= BCS_DONE;
					else if (rda == tda)
						state_reg <= BCS_HALTED;
					else
						state_reg <= BCS_CMD;
				end
				BCS_CMD: begin
					// phase 0 receive command, phase 1 transmit command
					if (phase_reg == 2'h0 && (rx_own || pushing))
						phase_reg <= 2'h1;
					if (phase_reg == 2'h1 && (tx_own || pushing))
						state_reg <= BCS_DATA;
				end
				BCS_DATA: begin
					if (is_mode && (cnt >= MC_UNDEF_LO || !data_out))
						state_reg <= BCS_RESULT;
					else if (!is_mode)
						state_reg <= BCS_RESULT;
					else if (is_mode && pushing)
						state_reg <= BCS_RESULT;
				end
				BCS_RESULT: begin
					if (xfer_done) begin
						if (xfer_ok)
							state_reg <= BCS_DONE;
						else if (iw1_reg[RETRY_BIT] && retry_reg != RETRY_MAX) begin
							retry_reg <= retry_reg + 2'h1;
							phase_reg <= 2'h0;
							state_reg <= BCS_CMD;
						end else
							state_reg <= BCS_DONE;
					end
				end
				BCS_DONE: state_reg <= BCS_FETCH1;
				BCS_PAUSE: begin
					if (continue_set)
						state_reg <= BCS_FETCH1;
				end
				default: state_reg <= BCS_IDLE;
			endcase
		end
	end

	// bus word source and bus select
	always_comb begin
		bw_valid = 1'b0;
		bw_data = 16'h0000;
		if (state_reg == BCS_CMD && phase_reg == 2'h0 && !rx_own) begin
			bw_valid = 1'b1;
			bw_data = bcseq_cmd(rda, DIR_RX, rsa, cnt);
		end else if (state_reg == BCS_CMD && phase_reg == 2'h1 && !tx_own) begin
			bw_valid = 1'b1;
			bw_data = bcseq_cmd(tda, DIR_TX, tsa, cnt);
		end else if (state_reg == BCS_DATA && is_mode && data_out && cnt < MC_UNDEF_LO) begin
			bw_valid = 1'b1;
			bw_data = mode_payload_register;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_word_is_cmd <= 1'b0;
			bus_select <= 1'b0;
			expect_status_only <= 1'b0;
		end else begin
			bus_word_is_cmd <= (state_reg == BCS_CMD);
			if (state_reg == BCS_DECODE && iw1_reg[OP_HI:OP_LO] == OP_BUS)
				bus_select <= iw2_reg[BSEL_BIT];
			expect_status_only <= is_mode && cnt >= MC_UNDEF_LO;
		end
	end

	// memory port: instruction fetch and data store for own receive; no data fetch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else if (mem_go) begin
			mem_req <= 1'b0;
		end else if (!mem_req) begin
			mem_we <= 1'b0;
			if (state_reg == BCS_FETCH1 || state_reg == BCS_FETCH2) begin
				mem_req <= 1'b1;
				mem_addr <= instruction_pointer_register;
			end else if (rx_word_valid && rx_own && !is_mode && state_reg == BCS_RESULT) begin
				mem_req <= 1'b1;
				mem_we <= 1'b1;
				mem_addr <= transfer_address_register;
				mem_wdata <= rx_word;
			end
		end
	end

	// transfer address and remaining count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			transfer_address_register <= 16'h0000;
			remaining_count_register <= 5'h00;
		end else if (state_reg == BCS_DECODE && iw1_reg[OP_HI:OP_LO] == OP_BUS) begin
			remaining_count_register <= cnt;
			if (rx_own && rsa != ZERO5)
				transfer_address_register <= {11'h000, rsa} + ONE;
			else
				transfer_address_register <= data_area_pointer + ONE;
		end else if (mem_go && mem_we) begin
			transfer_address_register <= transfer_address_register + ONE;
			remaining_count_register <= remaining_count_register - CNT_ONE;
		end
	end

	// mode payload: host load, returned mode data
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mode_payload_register <= 16'h0000;
		else if (rx_word_valid && is_mode && rx_own && state_reg == BCS_RESULT)
			mode_payload_register <= rx_word;
		else if (mode_payload_load)
			mode_payload_register <= mode_payload_in;
	end

	// internal status flags and level 1 interrupt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			halt_flag <= 1'b0;
			pci_flag <= 1'b0;
			invalid_instruction_flag <= 1'b0;
			level1_irq <= 1'b0;
			paused <= 1'b0;
		end else begin
			level1_irq <= 1'b0;
			paused <= (state_reg == BCS_PAUSE);
			if (start)
				halt_flag <= 1'b0;
			if (start)
				invalid_instruction_flag <= 1'b0;
			if (start)
				pci_flag <= 1'b0;
			if (state_reg == BCS_DECODE && iw1_reg[OP_HI:OP_LO] == OP_HALT) begin
				halt_flag <= 1'b1;
				level1_irq <= 1'b1;
			end
			if (state_reg == BCS_DECODE && iw1_reg[OP_HI:OP_LO] == OP_BUS && rda == tda) begin
				invalid_instruction_flag <= 1'b1;
				level1_irq <= 1'b1;
			end
			if (iw1_reg[INTR_BIT] && ((state_reg == BCS_RESULT && xfer_done && xfer_ok)
					|| (state_reg == BCS_DECODE && iw1_reg[OP_HI:OP_LO] == OP_NOP))) begin
				pci_flag <= 1'b1;
				level1_irq <= 1'b1;
			end
		end
	end

	// remote-mode mode code handling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mfr_wait_reg <= 1'b0;
			master_function_register <= 16'h0000;
			master_function_irq <= 1'b0;
			system_irq <= 1'b0;
			busy_continue <= 1'b0;
			invalid_command_bit <= 1'b0;
			status_error_reply <= 1'b0;
		end else begin
			master_function_irq <= 1'b0;
			system_irq <= 1'b0;
			status_error_reply <= 1'b0;
			if (busy_continue_set)
				busy_continue <= 1'b1;
			if (mfr_wait_reg && remote_data_valid) begin
				master_function_register <= remote_data;
				master_function_irq <= 1'b1;
				mfr_wait_reg <= 1'b0;
			end
			if (!master_mode && remote_cmd_valid) begin
				if (!bcseq_remote_valid(remote_mode_code)) begin
					invalid_command_bit <= 1'b1;
					status_error_reply <= 1'b1;
				end else if (remote_mode_code == MC_MFI)
					mfr_wait_reg <= 1'b1;
				else if (remote_mode_code == MC_BUSY_OVR)
					busy_continue <= 1'b0;
				else if (remote_mode_code == MC_SYS_INT)
					system_irq <= 1'b1;
			end
		end
	end
endmodule : bcseq_top

//--- sim/bcseq_checker.sv
/*
 bcseq_checker: port-level assertions for bcseq_top.
 Assumes one clock domain with the async active-high reset.
*/
`timescale 1ns/1ps
module bcseq_checker
	import bcseq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic master_mode,
	input wire logic start,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [AW-1:0] mem_addr,
	input wire logic bus_word_valid,
	input wire logic remote_cmd_valid,
	input wire logic [4:0] remote_mode_code,
	input wire logic halt_flag,
	input wire logic invalid_instruction_flag,
	input wire logic level1_irq,
	input wire logic busy_continue,
	input wire logic system_irq,
	input wire logic status_error_reply
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_fetch_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("fetch request moved before acknowledge");
	a_remote_quiet: assert property (!master_mode |-> !bus_word_valid)
		else $error("remote unit offered a bus word");
	a_halt_irq: assert property ($rose(halt_flag) |-> level1_irq)
		else $error("halt without level 1 interrupt");
	a_ivi_irq: assert property ($rose(invalid_instruction_flag) |-> level1_irq)
		else $error("invalid instruction without interrupt");
	a_halt_idle: assert property (halt_flag && !start |=> !mem_req)
		else $error("fetch while halted");
	a_busy_clear: assert property (!master_mode && remote_cmd_valid
		&& remote_mode_code == MC_BUSY_OVR |-> ##[1:3] !busy_continue)
		else $error("busy override left busy set");
	a_sys_irq: assert property (!master_mode && remote_cmd_valid
		&& remote_mode_code == MC_SYS_INT |-> ##[1:3] system_irq)
		else $error("no system interrupt");
	a_bad_code: assert property (!master_mode && remote_cmd_valid
		&& remote_mode_code inside {5'h00, 5'h02, 5'h08} |-> ##[1:8] status_error_reply)
		else $error("invalid code not answered with error");
	a_master_deaf: assert property (master_mode && remote_cmd_valid |=> !system_irq [*3])
		else $error("master reacted to remote command");
endmodule : bcseq_checker
bind bcseq_top bcseq_checker u_bcseq_checker (.*);

//--- sim/bcseq_far_model.sv
/*
 bcseq_far_model: main memory and bus engine facing the sequencer.
 Assumes the request/acknowledge memory port and the buffered word handshake.
*/
`timescale 1ns/1ps
module bcseq_far_model
	import bcseq_pkg::*;
(
	input wire logic clk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [AW-1:0] mem_addr,
	output logic mem_ack,
	output logic [W-1:0] mem_rdata,
	input wire logic [W-1:0] bus_word,
	input wire logic bus_word_valid,
	output logic bus_word_ready,
	output logic xfer_done,
	output logic xfer_ok
);
	logic [W-1:0] mem [256];
	logic [W-1:0] cmds [$];
	logic [AW-1:0] rd_addr [$];
	int fail_left = 0;
	int quiet = 0;
	logic busy = 1'b0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h5A5A;
		bus_word_ready = 1'b0;
		xfer_done = 1'b0;
		xfer_ok = 1'b0;
	end
	// memory answers after a random wait, scrambled data when not answering
	always @(posedge clk) begin
		mem_ack <= mem_req && !mem_ack && ($urandom_range(1, 0) == 1);
		if (mem_req && !mem_ack) begin
			mem_rdata <= mem[mem_addr[7:0]];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
		if (mem_req && mem_ack && !mem_we) begin
			rd_addr.push_back(mem_addr);
		end
	end
	// bus engine stalls at random, reports a result once the buffer runs dry
	always @(posedge clk) begin
		bus_word_ready <= ($urandom_range(3, 0) != 0);
		xfer_done <= 1'b0;
		xfer_ok <= 1'b0;
		if (bus_word_valid && bus_word_ready) begin
			cmds.push_back(bus_word);
			busy = 1'b1;
			quiet = 0;
		end else if (busy && !bus_word_valid) begin
			quiet++;
			if (quiet == 4) begin
				xfer_done <= 1'b1;
				xfer_ok <= (fail_left == 0);
				if (fail_left > 0) fail_left--;
				busy = 1'b0;
			end
		end
	end
endmodule : bcseq_far_model

//--- sim/bcseq_top_tb.sv
/*
 bcseq_top_tb: self-checking bench for the command-list sequencer.
 Assumes bcseq_far_model as memory and bus engine, checker bound to bcseq_top.
*/
`timescale 1ns/1ps
module bcseq_top_tb
	import bcseq_pkg::*;
;
	logic clk = 0, rst = 1, master_mode = 1, start = 0, continue_set = 0;
	logic mode_payload_load = 0, busy_continue_set = 0, rx_word_valid = 0;
	logic remote_cmd_valid = 0, remote_data_valid = 0;
	logic [4:0] own_address = 5'h00, remote_mode_code = 5'h00, remaining_count_register;
	logic [AW-1:0] start_address = 16'h0000, data_area_pointer = 16'h0000;
	logic [AW-1:0] mem_addr, transfer_address_register, instruction_pointer_register;
	logic [W-1:0] mode_payload_in = 16'h0000, rx_word = 16'h0000, remote_data = 16'h0000;
	logic [W-1:0] mem_rdata, mem_wdata, bus_word, mode_payload_register, master_function_register;
	logic mem_req, mem_we, mem_ack, bus_word_valid, bus_word_ready, bus_word_is_cmd, bus_select;
	logic expect_status_only, xfer_done, xfer_ok, halt_flag, pci_flag, invalid_instruction_flag;
	logic level1_irq, master_function_irq, system_irq, busy_continue, invalid_command_bit;
	logic status_error_reply, paused;
	int errors = 0;
	int n_checks = 0;
	bcseq_top u_bcseq_top (.*);
	bcseq_far_model u_bcseq_far_model (.*);
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("unexpected timeout: expected end seen hang");
		finish_test();
	end
	task automatic chk(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	function automatic logic [W-1:0] in1(logic [1:0] op, logic rt, logic ir, logic [4:0] da,
			logic [4:0] sa);
		return {op, rt, 1'b0, ir, da, 1'b0, sa};
	endfunction : in1
	function automatic logic [W-1:0] cmdw(logic [4:0] da, logic dir, logic [4:0] sa,
			logic [4:0] n);
		return {da, dir, sa, n};
	endfunction : cmdw
	function automatic logic ok(logic [4:0] m);
		return m inside {5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h11, 5'h12,
			5'h14, 5'h15};
	endfunction : ok
	task automatic put(input logic [7:0] a, input logic [W-1:0] w1, input logic [W-1:0] w2);
		u_bcseq_far_model.mem[a] = w1;
		u_bcseq_far_model.mem[a + 8'h01] = w2;
	endtask : put
	task automatic run(input logic [AW-1:0] a);
		start_address <= a;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : run
	// 0 paused, 1 halted, 2 invalid instruction
	task automatic wt(input int w);
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk);
			if ((w == 0 && paused === 1'b1) || (w == 1 && halt_flag === 1'b1)
					|| (w == 2 && invalid_instruction_flag === 1'b1)) return;
		end
		chk("wait", 16'h0001, 16'h0000);
	endtask : wt
	// result bits: error reply, system interrupt, master function interrupt
	task automatic send(input logic [4:0] mc, input logic [W-1:0] d, output logic [2:0] r);
		remote_cmd_valid <= 1'b1;
		remote_mode_code <= mc;
		@(posedge clk);
		remote_cmd_valid <= 1'b0;
		remote_data_valid <= (mc == MC_MFI);
		remote_data <= d;
		r = 3'h0;
		repeat (9) begin
			#1;
			r = r | {status_error_reply, system_irq, master_function_irq};
			@(posedge clk);
			remote_data_valid <= 1'b0;
		end
	endtask : send
	initial begin
		logic [4:0] own, ra, ta, sa, sb, cnt, mc;
		logic [W-1:0] d;
		logic [2:0] r;
		void'($urandom(32'h7AB0));
		own = 5'($urandom_range(28, 1));
		ra = own + 5'h01;
		ta = own + 5'h02;
		sa = 5'($urandom_range(31, 1));
		sb = 5'($urandom_range(31, 1));
		cnt = 5'($urandom);
		d = 16'($urandom);
		own_address = own;
		data_area_pointer = d;
		put(8'h10, in1(OP_BUS, 1'b0, 1'b1, ra, sa), {cnt, 1'b1, own, ZERO5});
		put(8'h12, in1(OP_NOP, 1'b0, 1'b1, ZERO5, ZERO5), 16'h0000);
		put(8'h14, 16'h0000, 16'h0000);
		put(8'h20, in1(OP_BUS, 1'b1, 1'b0, ra, sa), {cnt, 1'b0, own, ZERO5});
		put(8'h22, in1(OP_BUS, 1'b0, 1'b0, own, sb), {cnt, 1'b0, ta, sa});
		put(8'h24, 16'h0000, 16'h0000);
		put(8'h28, in1(OP_BUS, 1'b0, 1'b0, ta, sa), {cnt, 1'b0, ta, sb});
		put(8'h30, in1(OP_BUS, 1'b1, 1'b0, ra, sa), {cnt, 1'b0, own, ZERO5});
		put(8'h32, 16'h0000, 16'h0000);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		run(16'h0010);
		wt(0);
		mode_payload_in <= ~d;
		mode_payload_load <= 1'b1;
		@(posedge clk);
		mode_payload_load <= 1'b0;
		@(posedge clk);
		chk("payload", ~d, mode_payload_register);
		continue_set <= 1'b1;
		@(posedge clk);
		continue_set <= 1'b0;
		wt(1);
		chk("sends", 16'h0001, 16'(u_bcseq_far_model.cmds.size()));
		chk("rx cmd", cmdw(ra, DIR_RX, sa, cnt), u_bcseq_far_model.cmds[0]);
		chk("bus 2", 16'h0001, 16'(bus_select));
		chk("pci", 16'h0001, 16'(pci_flag));
		chk("fetch 1", 16'h0010, u_bcseq_far_model.rd_addr[0]);
		chk("fetch 2", 16'h0011, u_bcseq_far_model.rd_addr[1]);
		send(MC_SYS_INT, d, r);
		chk("master deaf", 16'h0000, 16'(r));
		chk("fetches", 16'h0006, 16'(u_bcseq_far_model.rd_addr.size()));
		u_bcseq_far_model.cmds.delete();
		u_bcseq_far_model.fail_left = 2;
		run(16'h0020);
		wt(1);
		chk("sends", 16'h0004, 16'(u_bcseq_far_model.cmds.size()));
		chk("retry cmd", cmdw(ra, DIR_RX, sa, cnt), u_bcseq_far_model.cmds[2]);
		chk("tx cmd", cmdw(ta, DIR_TX, sa, cnt), u_bcseq_far_model.cmds[3]);
		chk("own sub", 16'(sb) + ONE, transfer_address_register);
		chk("bus 1", 16'h0000, 16'(bus_select));
		u_bcseq_far_model.cmds.delete();
		run(16'h0028);
		wt(2);
		chk("same dev", 16'h0000, 16'(u_bcseq_far_model.cmds.size()));
		u_bcseq_far_model.fail_left = 9;
		run(16'h0030);
		for (int k = 0; k < 3000 && u_bcseq_far_model.cmds.size() < 4; k++) @(posedge clk);
		repeat (200) @(posedge clk);
		chk("retry cap", 16'h0004, 16'(u_bcseq_far_model.cmds.size()));
		u_bcseq_far_model.fail_left = 0;
		master_mode <= 1'b0;
		busy_continue_set <= 1'b1;
		@(posedge clk);
		busy_continue_set <= 1'b0;
		@(posedge clk);
		chk("busy set", 16'h0001, 16'(busy_continue));
		for (int m = 0; m < 32; m++) begin
			mc = 5'(m);
			d = 16'($urandom);
			send(mc, d, r);
			chk("mode err", 16'(!ok(mc)), 16'(r[2]));
			chk("sys irq", 16'(mc == MC_SYS_INT), 16'(r[1]));
			chk("mfi irq", 16'(mc == MC_MFI), 16'(r[0]));
			if (mc == MC_MFI) chk("mfr", d, master_function_register);
			if (mc == MC_BUSY_OVR) chk("busy clr", 16'h0000, 16'(busy_continue));
			if (mc == ZERO5) chk("bit flag", 16'h0001, 16'(invalid_command_bit));
		end
		finish_test();
	end
endmodule : bcseq_top_tb
